/* hdl/mss_datapath.sv */
// subtract, nibble swap and skip-if-nonnull datapath with apb register access
//
// Functional notes
// - skip_nonnull_op skips the next instruction when the memory byte is nonzero
// - a taken skip adds one dummy cycle, making the instruction two cycles
// - memory subtract puts working_register minus memory byte into working_register
// - carry is 0 on a negative difference, 1 on zero or positive
// - subtract updates six arithmetic flags only; other status bits keep value
// - minus_to_memory_op stores working_register minus memory byte into that byte
// - immediate subtract puts working_register minus the immediate into working_register
// - in-place swap exchanges memory byte nibbles, writes back, flags unchanged
// - nibble_exchange_to_working_op loads swapped byte into working_register, memory unchanged
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mss_datapath (
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [mss_pkg::MSS_AW-1:0] paddr,
   input  wire logic [mss_pkg::MSS_DW-1:0] pwdata,
   output logic      [mss_pkg::MSS_DW-1:0] prdata,
   output logic                          pready,
   output logic                          pslverr,
   // pipeline control
   output logic                          dummy_cycle
);
   import mss_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // state and registers
   mss_state_t state;
   mss_state_t next_state;
   logic [7:0] working_register;
   logic [7:0] flags;
   logic [7:0] imm;
   logic [2:0] op;
   logic [3:0] op_addr;
   logic [3:0] mem_addr;
   logic       last_skip;
   logic [1:0] last_cycles;

   mss_mem_if mem_port ();

   mss_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .port    (mem_port)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire       access    = psel & penable & ~pready;
   wire       idle      = (state == MSS_IDLE);
   wire       take      = access & idle;
   wire       sel_cmd   = (paddr == MSS_ADDR_CMD);
   wire       sel_wreg  = (paddr == MSS_ADDR_WREG);
   wire       sel_flags = (paddr == MSS_ADDR_FLAGS);
   wire       sel_stat  = (paddr == MSS_ADDR_STAT);
   wire       sel_maddr = (paddr == MSS_ADDR_MADDR);
   wire       sel_mdata = (paddr == MSS_ADDR_MDATA);
   wire       mapped    = sel_cmd | sel_wreg | sel_flags | sel_stat | sel_maddr | sel_mdata;
   wire [2:0] cmd_op    = pwdata[MSS_CMD_OP_MSB:MSS_CMD_OP_LSB];
   wire       op_ok     = (cmd_op >= MSS_OP_SKIP_NZ) && (cmd_op <= MSS_OP_SWAP_WREG);
   // a bad opcode is refused with an error so software never waits on a no-op
   wire       cmd_err   = sel_cmd & pwrite & ~op_ok;
   wire       start     = take & sel_cmd & pwrite & op_ok;
   wire       mrd_start = take & sel_mdata & ~pwrite;
   wire       reg_wr    = take & pwrite & mapped & ~cmd_err;
   wire       mwr       = reg_wr & sel_mdata;
   wire       bad_now   = ~mapped | cmd_err;

   wire [7:0]  stat_byte = {2'b00, last_cycles, 3'b000, last_skip};
   wire [31:0] rd_mux    = sel_wreg  ? {24'h00_0000, working_register} :
                           sel_flags ? {24'h00_0000, flags} :
                           sel_stat  ? {24'h00_0000, stat_byte} :
                           sel_maddr ? {28'h000_0000, mem_addr} :
                           sel_cmd   ? {8'h00, imm, 4'h0, op_addr, 5'h00, op} :
                           MSS_WORD_ZERO;

   ////////////////////////////////////////////////////////////////////////////////
   // execution datapath
   wire       exec    = (state == MSS_EXEC);
   wire [7:0] m       = mem_port.rdata;
   wire       is_subi = (op == MSS_OP_SUBI);
   wire       is_sub  = (op == MSS_OP_SUB_WREG) | (op == MSS_OP_SUB_MEM) | is_subi;
   wire [7:0] sub_b   = is_subi ? imm : m;
   wire [8:0] diff    = {1'b0, working_register} - {1'b0, sub_b};
   wire [4:0] nib     = {1'b0, working_register[3:0]} - {1'b0, sub_b[3:0]};
   wire [7:0] res     = diff[7:0];
   wire       f_c     = ~diff[8];
   wire       f_half  = ~nib[4];
   wire       f_z     = (res == MSS_BYTE_ZERO);
   wire       f_wrap  = (working_register[7] ^ sub_b[7]) & (working_register[7] ^ res[7]);
   wire       f_sbor  = f_wrap ^ res[7];
   wire       f_cnull = f_z;
   wire [7:0] swapped = {m[3:0], m[7:4]};
   wire       skip    = (op == MSS_OP_SKIP_NZ) & (m != MSS_BYTE_ZERO);

   logic [7:0] sub_flags;
   always_comb begin
      sub_flags             = flags;
      sub_flags[MSS_FLG_C]  = f_c;
      sub_flags[MSS_FLG_HALF]  = f_half;
      sub_flags[MSS_FLG_Z]     = f_z;
      sub_flags[MSS_FLG_WRAP]  = f_wrap;
      sub_flags[MSS_FLG_SBOR]  = f_sbor;
      sub_flags[MSS_FLG_CNULL] = f_cnull;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // memory port
   wire mem_wb = exec & ((op == MSS_OP_SUB_MEM) | (op == MSS_OP_SWAP));
   assign mem_port.we    = mwr | mem_wb;
   assign mem_port.addr  = idle ? mem_addr : op_addr;
   assign mem_port.wdata = ~exec ? pwdata[7:0] :
                           (op == MSS_OP_SWAP) ? swapped : res;

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         MSS_IDLE: begin
            if (start) begin
               next_state = MSS_FETCH;
            end else if (mrd_start) begin
               next_state = MSS_MRD;
            end
         end
         MSS_FETCH: begin
            next_state = MSS_EXEC;
         end
         MSS_EXEC: begin
            next_state = skip ? MSS_DUMMY : MSS_IDLE;
         end
         MSS_DUMMY: begin
            next_state = MSS_IDLE;
         end
         MSS_MRD: begin
            next_state = MSS_IDLE;
         end
         default: begin
            next_state = MSS_IDLE;
         end
      endcase
   end

   wire        next_pready  = (take & ~mrd_start) | (state == MSS_MRD);
   wire        next_pslverr = take & ~mrd_start & bad_now;
   wire [31:0] next_prdata  = (state == MSS_MRD) ? {24'h00_0000, m} :
                              (take & ~pwrite) ? rd_mux : MSS_WORD_ZERO;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= MSS_IDLE;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         prdata      <= MSS_WORD_ZERO;
         dummy_cycle <= 1'b0;
      end else begin
         state       <= next_state;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
         prdata      <= next_prdata;
         dummy_cycle <= (next_state == MSS_DUMMY);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software-visible registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_register <= MSS_BYTE_ZERO;
      end else if (exec & ((op == MSS_OP_SUB_WREG) | is_subi)) begin
         working_register <= res;
      end else if (exec & (op == MSS_OP_SWAP_WREG)) begin
         working_register <= swapped;
      end else if (reg_wr & sel_wreg) begin
         working_register <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= MSS_BYTE_ZERO;
      end else if (exec & is_sub) begin
         flags <= sub_flags;
      end else if (reg_wr & sel_flags) begin
         flags <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op      <= MSS_OP_RST;
         op_addr <= MSS_MADDR_RST;
         imm     <= MSS_BYTE_ZERO;
      end else if (start) begin
         op      <= cmd_op;
         op_addr <= pwdata[MSS_CMD_AD_MSB:MSS_CMD_AD_LSB];
         imm     <= pwdata[MSS_CMD_IM_MSB:MSS_CMD_IM_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= MSS_MADDR_RST;
      end else if (reg_wr & sel_maddr) begin
         mem_addr <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_skip   <= 1'b0;
         last_cycles <= MSS_CYC_RST;
      end else if (exec) begin
         last_skip   <= skip;
         last_cycles <= skip ? MSS_CYC_TWO : MSS_CYC_ONE;
      end
   end
endmodule
`default_nettype wire

/* hdl/mss_pkg.sv */
// constants, encodings and state type for the subtract/swap/skip datapath
package mss_pkg;
   // apb register map, byte addresses
   localparam int unsigned  MSS_AW          = 8;
   localparam int unsigned  MSS_DW          = 32;
   localparam logic [7:0]   MSS_ADDR_CMD    = 8'h00;
   localparam logic [7:0]   MSS_ADDR_WREG   = 8'h04;
   localparam logic [7:0]   MSS_ADDR_FLAGS  = 8'h08;
   localparam logic [7:0]   MSS_ADDR_STAT   = 8'h0c;
   localparam logic [7:0]   MSS_ADDR_MADDR  = 8'h10;
   localparam logic [7:0]   MSS_ADDR_MDATA  = 8'h14;
   // command word fields
   localparam int unsigned  MSS_CMD_OP_LSB  = 0;
   localparam int unsigned  MSS_CMD_OP_MSB  = 2;
   localparam int unsigned  MSS_CMD_AD_LSB  = 8;
   localparam int unsigned  MSS_CMD_AD_MSB  = 11;
   localparam int unsigned  MSS_CMD_IM_LSB  = 16;
   localparam int unsigned  MSS_CMD_IM_MSB  = 23;
   // opcodes
   localparam logic [2:0]   MSS_OP_SKIP_NZ  = 3'h1;
   localparam logic [2:0]   MSS_OP_SUB_WREG = 3'h2;
   localparam logic [2:0]   MSS_OP_SUB_MEM  = 3'h3;
   localparam logic [2:0]   MSS_OP_SUBI     = 3'h4;
   localparam logic [2:0]   MSS_OP_SWAP     = 3'h5;
   localparam logic [2:0]   MSS_OP_SWAP_WREG = 3'h6;
   // flag bit positions; bits 6 and 7 are other status bits, untouched by subtract
   localparam int unsigned  MSS_FLG_C       = 0;
   localparam int unsigned  MSS_FLG_HALF    = 1;
   localparam int unsigned  MSS_FLG_Z       = 2;
   localparam int unsigned  MSS_FLG_WRAP    = 3;
   localparam int unsigned  MSS_FLG_SBOR    = 4;
   localparam int unsigned  MSS_FLG_CNULL   = 5;
   // status register fields
   localparam int unsigned  MSS_STAT_SKIP   = 0;
   localparam int unsigned  MSS_STAT_CY_LSB = 4;
   localparam int unsigned  MSS_STAT_CY_MSB = 5;
   localparam logic [1:0]   MSS_CYC_ONE     = 2'h1;
   localparam logic [1:0]   MSS_CYC_TWO     = 2'h2;
   // data memory
   localparam int unsigned  MSS_MAW         = 4;
   localparam int unsigned  MSS_MEM_DEPTH   = 16;
   // reset values
   localparam logic [7:0]   MSS_BYTE_ZERO   = 8'h00;
   localparam logic [31:0]  MSS_WORD_ZERO   = 32'h0000_0000;
   localparam logic [2:0]   MSS_OP_RST      = 3'h0;
   localparam logic [3:0]   MSS_MADDR_RST   = 4'h0;
   localparam logic [1:0]   MSS_CYC_RST     = 2'h0;
   // gray codes along idle, fetch, exec, dummy
   typedef enum logic [2:0] {
      MSS_IDLE  = 3'h0,
      MSS_FETCH = 3'h1,
      MSS_EXEC  = 3'h3,
      MSS_DUMMY = 3'h2,
      MSS_MRD   = 3'h4
   } mss_state_t;
endpackage

/* hdl/mss_mem_if.sv */
// data memory port between the datapath and its byte memory
`timescale 1ns/1ps
`default_nettype none
interface mss_mem_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       we;
   logic [7:0] rdata;
   modport ctrl (output addr, output wdata, output we, input rdata);
   modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

/* hdl/mss_mem.sv */
// byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mss_mem (
   // clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // memory port
   mss_mem_if.mem    port
);
   import mss_pkg::*;
   logic [7:0] array [MSS_MEM_DEPTH];
   // array has no reset; only the read register starts defined
   always_ff @(posedge pclk) begin
      if (port.we) begin
         array[port.addr] <= port.wdata;
      end
   end
   // read-before-write: a same-cycle write is not seen until the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port.rdata <= MSS_BYTE_ZERO;
      end else begin
         port.rdata <= array[port.addr];
      end
   end
endmodule
`default_nettype wire

/* verification/mss_datapath_checker.sv */
// port-level assertions for the subtract, swap and skip datapath
`timescale 1ns/1ps
`default_nettype none
module mss_datapath_checker (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb and pipeline
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dummy_cycle
);
   import mss_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic in_access = psel && penable && !pready;
   ////////////////////////////////////////////////////////////////
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   a_err_qualified: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_quiet: assert property (!pready |-> prdata == MSS_WORD_ZERO)
      else $error("prdata nonzero outside answer");
   a_dummy_pulse: assert property (dummy_cycle |=> !dummy_cycle)
      else $error("dummy cycle longer than one cycle");
   a_dummy_cause: assert property (dummy_cycle |-> $past(pready && pwrite, 2))
      else $error("dummy cycle not two cycles after command");
   a_badop_refused: assert property (in_access && pwrite && paddr == MSS_ADDR_CMD
      && pwdata[2:0] == 3'h7 |-> ##[1:6] pready && pslverr)
      else $error("bad opcode not refused");
   a_unmapped_refused: assert property (in_access && paddr == 8'h20 |-> ##[1:6] pready && pslverr)
      else $error("unmapped access not refused");
endmodule
bind mss_datapath mss_datapath_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .dummy_cycle(dummy_cycle));
`default_nettype wire

/* verification/mss_datapath_tb_top.sv */
// self-checking testbench for the subtract, swap and skip datapath
`timescale 1ns/1ps
`default_nettype none
module mss_datapath_tb_top;
   import mss_pkg::*;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        dummy_cycle;
   logic [31:0] rd;
   int          fail_count = 0;
   int          n_tests    = 0;
   int          dummy_cnt  = 0;
   int          cyc        = 0;
   always #2 pclk = ~pclk;
   mss_datapath dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dummy_cycle(dummy_cycle));
   ////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (dummy_cycle === 1'b1)
         dummy_cnt <= dummy_cnt + 1;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; read data lands in rd, pslverr in rd instead when asked
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic want_err = 1'b0);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: a missing answer is caught by the hang guard
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = want_err ? {31'h0, pslverr} : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] cmd(logic [2:0] op, logic [3:0] a, logic [7:0] im);
      return {8'h00, im, 4'h0, a, 5'h00, op};
   endfunction
   function automatic logic [7:0] exp_flags(logic [7:0] w, logic [7:0] m);
      logic [7:0] r;
      logic       wrap;
      r = w - m;
      wrap = (w[7] != m[7]) && (r[7] != w[7]);
      return {2'h3, r == 8'h00, wrap ^ r[7], wrap, r == 8'h00, w[3:0] >= m[3:0], w >= m};
   endfunction
   ////////////////////////////////////////////////////////////////
   // negative, zero, signed wrap and nibble borrow cases
   task automatic run_sub(logic [2:0] op);
      logic [7:0] w [4] = '{8'h10, 8'h20, 8'h80, 8'h35};
      logic [7:0] m [4] = '{8'h20, 8'h20, 8'h01, 8'h07};
      logic [7:0] r;
      for (int i = 0; i < 4; i++) begin
         r = w[i] - m[i];
         apb(1'b1, MSS_ADDR_WREG, {24'h0, w[i]});
         apb(1'b1, MSS_ADDR_MADDR, 32'h9);
         apb(1'b1, MSS_ADDR_MDATA, {24'h0, m[i]});
         apb(1'b1, MSS_ADDR_FLAGS, 32'hc0);
         apb(1'b1, MSS_ADDR_CMD, cmd(op, 4'h9, m[i]));
         apb(1'b0, MSS_ADDR_FLAGS, 0);
         chk("flags", exp_flags(w[i], m[i]), rd);
         apb(1'b0, MSS_ADDR_WREG, 0);
         chk("wreg", op == MSS_OP_SUB_MEM ? w[i] : r, rd);
         apb(1'b0, MSS_ADDR_MDATA, 0);
         chk("mem", op == MSS_OP_SUB_MEM ? r : m[i], rd);
      end
      $display("test subtract op %0d done", op);
   endtask
   task automatic t_swap();
      apb(1'b1, MSS_ADDR_MADDR, 32'h2);
      apb(1'b1, MSS_ADDR_MDATA, 32'h5a);
      apb(1'b1, MSS_ADDR_FLAGS, 32'h3f);
      apb(1'b1, MSS_ADDR_WREG, 32'h0);
      apb(1'b1, MSS_ADDR_CMD, cmd(MSS_OP_SWAP, 4'h2, 8'h00));
      apb(1'b0, MSS_ADDR_MDATA, 0);
      chk("mem", 32'ha5, rd);
      apb(1'b1, MSS_ADDR_CMD, cmd(MSS_OP_SWAP_WREG, 4'h2, 8'h00));
      apb(1'b0, MSS_ADDR_WREG, 0);
      chk("wreg", 32'h5a, rd);
      apb(1'b0, MSS_ADDR_MDATA, 0);
      chk("mem", 32'ha5, rd);
      apb(1'b0, MSS_ADDR_FLAGS, 0);
      chk("flags", 32'h3f, rd);
      $display("test swap done");
   endtask
   // only bit 7 set: the whole byte must be tested, not bit 0
   task automatic t_skip();
      int n;
      for (int i = 0; i < 2; i++) begin
         n = dummy_cnt;
         apb(1'b1, MSS_ADDR_MDATA, i ? 32'h80 : 32'h0);
         apb(1'b1, MSS_ADDR_CMD, cmd(MSS_OP_SKIP_NZ, 4'h2, 8'h00));
         apb(1'b0, MSS_ADDR_STAT, 0);
         chk("skip", i, rd[0]);
         chk("cycles", i ? 2 : 1, rd[5:4]);
         chk("dummies", i, dummy_cnt - n);
      end
      $display("test skip done");
   endtask
   task automatic t_refuse();
      apb(1'b1, MSS_ADDR_CMD, 32'h7, 1'b1);
      chk("bad op err", 1, rd);
      apb(1'b1, MSS_ADDR_CMD, 32'h0, 1'b1);
      chk("null op err", 1, rd);
      // status write is accepted without error and changes nothing
      apb(1'b1, MSS_ADDR_STAT, 32'h0, 1'b1);
      chk("stat write err", 0, rd);
      // last op was a taken skip; refused commands must not have started
      apb(1'b0, MSS_ADDR_STAT, 0);
      chk("stat kept", 32'h21, rd);
      apb(1'b0, MSS_ADDR_WREG, 0, 1'b1);
      chk("mapped read err", 0, rd);
      apb(1'b0, 8'h20, 0, 1'b1);
      chk("unmapped err", 1, rd);
      apb(1'b0, 8'h20, 0);
      chk("unmapped data", 0, rd);
      $display("test refuse done");
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      run_sub(MSS_OP_SUB_WREG);
      run_sub(MSS_OP_SUB_MEM);
      run_sub(MSS_OP_SUBI);
      t_swap();
      t_skip();
      t_refuse();
      conclude();
   end
endmodule
`default_nettype wire
